// ===== slb_pkg.sv
// What this block does
// - Autobaud counts five rising edges, stores divisor
// - Counter wrap before fifth edge sets overflow
// - Overflow sets pending; counting continues to fifth
// - Idle flag low until fifth autobaud edge
// - Fifth edge sets pending again after read
// - Early autobaud stop: later edges are starts
// - Wake enable holds receiver idle, watches falls
// - Wake falling edge sets pending; read clears
// - Rising edge ends break, clears wake enable
// - Nonzero character: first low is wake event
// - Break is start, twelve zeros, stop
// - Data write with break request sends zeros
// - Break request clears after stop; next byte follows
// - Received break shows pending, framing error, zero
// - Synchronous mode sends no start or stop
// - Mode bits select synchronous master transmit
// - Master drives one clock per data bit
// - Polarity sets clock idle level and edge
// - Transmit data waits until shifter empties
// - Master transmit drives data, changes on leading
package slb_pkg;

    typedef logic [3:0] slb_addr_t;
    typedef logic [7:0] slb_byte_t;

    // ====================================================
    // Register offsets
    localparam slb_addr_t OFS_CTRL = 4'h0;
    localparam slb_addr_t OFS_BAUD = 4'h1;
    localparam slb_addr_t OFS_STAT = 4'h2;
    localparam slb_addr_t OFS_TXDATA = 4'h3;
    localparam slb_addr_t OFS_RXDATA = 4'h4;
    localparam slb_addr_t OFS_DIVLO = 4'h5;
    localparam slb_addr_t OFS_DIVHI = 4'h6;

    // ====================================================
    // Control register layout, bit 0 last
    typedef struct packed {
        logic clock_idle_polarity;
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic clock_source_master;
        logic sync_mode;
        logic send_break_request;
        logic transmit_enable;
        logic port_enable;
    } slb_ctrl_s;

    // ====================================================
    // Field positions
    localparam int BAUD_ABD_EN = 0;
    localparam int BAUD_WAKE_EN = 1;
    localparam int BAUD_IDLE = 6;
    localparam int BAUD_OVF = 7;
    localparam int STAT_PEND = 0;
    localparam int STAT_FRAMING_ERROR_FLAG = 1;
    localparam int STAT_TXE = 2;
    localparam int STAT_TRMT = 3;

    // ====================================================
    // Reset values and counts
    localparam slb_byte_t CTRL_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0067;
    localparam logic [15:0] ABD_START = 16'h0001;
    localparam logic [15:0] ABD_MAX = 16'hFFFF;
    localparam logic [2:0] ABD_PRESCALE = 3'h7;
    localparam logic [2:0] ABD_EDGES = 3'h5;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] BRK_BITS = 4'hC;

endpackage

// ===== slb_sync2.sv
`timescale 1ns/1ps
module slb_sync2 (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_q;

    // ====================================================
    // Two-stage synchroniser, idles high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// ===== slb_rate_gen.sv
`timescale 1ns/1ps
module slb_rate_gen (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic [15:0] div_i,
    output logic tick_o,
    output logic half_o
);
    logic [15:0] cnt_q;

    // ====================================================
    // Bit-period divider, restartable
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i || cnt_q == div_i) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign tick_o = !restart_i && cnt_q == div_i;
    assign half_o = !restart_i && cnt_q == {1'b0, div_i[15:1]};
endmodule

// ===== slb_lin_serial.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module slb_lin_serial
    import slb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic clock_pin_i,
    output logic clock_pin_o,
    output logic clock_pin_oe_o,
    input wire logic data_pin_i,
    output logic data_pin_o,
    output logic data_pin_oe_o
);
    typedef enum logic [1:0] {AB_IDLE, AB_START, AB_COUNT} slb_abd_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} slb_rx_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_SLEAD, TX_STRAIL} slb_tx_e;

    function automatic logic sel(input logic strobe, input slb_addr_t a, input slb_addr_t ofs);
        sel = strobe && a == ofs;
    endfunction

    slb_ctrl_s ctrl_q;
    logic abd_en_q, wake_en_q, ovf_q, pend_q, framing_error_flag_q, wake_seen_q;
    logic [15:0] div_q, abd_cnt_q;
    logic [2:0] presc_q, edges_q, rx_bits_q;
    logic [3:0] tx_cnt_q;
    slb_byte_t rxbuf_q, rx_sh_q, hold_q, tsr_q, baud_rd, stat_rd;
    logic hold_full_q, hold_brk_q, tx_brk_q;
    slb_abd_e abd_q;
    slb_rx_e rx_q;
    slb_tx_e tx_q;
    logic rx_s, rx_prev_q, rx_fall, rx_rise, rx_tick, rx_half, tx_tick, tx_half;
    logic async_on, sync_tx, abd_go, wake_act, rx_go, recv_idle;
    logic presc_tick, abd_done, abd_ovf_evt, wake_evt, wake_end, rx_done;
    logic wr_baud, wr_tx_ok, rd_rx, load, brk_done;
    logic [3:0] nbits;

    // ====================================================
    // Mode decode
    assign async_on = ctrl_q.port_enable && !ctrl_q.sync_mode;
    assign sync_tx = ctrl_q.port_enable && ctrl_q.sync_mode && ctrl_q.clock_source_master
        && !ctrl_q.single_receive_enable && !ctrl_q.continuous_receive_enable;
    assign wake_act = wake_en_q && async_on;
    assign abd_go = abd_en_q && async_on && !wake_en_q;
    assign rx_go = async_on && ctrl_q.continuous_receive_enable && !abd_go && !wake_act;
    assign recv_idle = rx_q == RX_IDLE && !abd_go;
    assign wr_baud = sel(wr_i, addr_i, OFS_BAUD);
    assign rd_rx = sel(rd_i, addr_i, OFS_RXDATA);

    // ====================================================
    // Receive line sampling
    slb_sync2 u_rx_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(data_pin_i),
        .q_o(rx_s)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_s;
        end
    end

    assign rx_fall = rx_prev_q && !rx_s;
    assign rx_rise = !rx_prev_q && rx_s;

    slb_rate_gen u_rx_rate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(rx_q == RX_IDLE),
        .div_i(div_q),
        .tick_o(rx_tick),
        .half_o(rx_half)
    );

    slb_rate_gen u_tx_rate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(tx_q == TX_IDLE),
        .div_i(div_q),
        .tick_o(tx_tick),
        .half_o(tx_half)
    );

    // ====================================================
    // Control register
    assign brk_done = tx_q == TX_STOP && tx_tick && tx_brk_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= slb_ctrl_s'(CTRL_RST);
        end else if (sel(wr_i, addr_i, OFS_CTRL)) begin
            ctrl_q <= slb_ctrl_s'(wdata_i);
        end else if (brk_done) begin
            ctrl_q.send_break_request <= 1'b0;
        end
    end

    // ====================================================
    // Autobaud and wake controls
    assign presc_tick = abd_go && abd_q == AB_COUNT && presc_q == ABD_PRESCALE;
    assign abd_done = abd_go && abd_q == AB_COUNT && rx_rise && edges_q == ABD_EDGES - 3'h1;
    assign abd_ovf_evt = presc_tick && abd_cnt_q == ABD_MAX && !abd_done;
    assign wake_evt = wake_act && rx_fall && !wake_seen_q;
    assign wake_end = wake_act && rx_rise && wake_seen_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abd_en_q <= 1'b0;
            wake_en_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= abd_ovf_evt || (ovf_q && !(wr_baud && !wdata_i[BAUD_OVF]));
            if (wr_baud) begin
                abd_en_q <= wdata_i[BAUD_ABD_EN];
                wake_en_q <= wdata_i[BAUD_WAKE_EN];
            end else begin
                if (abd_done) begin
                    abd_en_q <= 1'b0;
                end
                if (wake_end) begin
                    wake_en_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || wr_baud || !wake_act) begin
            wake_seen_q <= 1'b0;
        end else if (wake_evt) begin
            wake_seen_q <= 1'b1;
        end else if (wake_end) begin
            wake_seen_q <= 1'b0;
        end
    end

    // ====================================================
    // Autobaud measurement
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abd_q <= AB_IDLE;
            abd_cnt_q <= ABD_START;
            presc_q <= 3'h0;
            edges_q <= 3'h0;
        end else if (!abd_go) begin
            abd_q <= AB_IDLE;
        end else begin
            unique case (abd_q)
                AB_IDLE: begin
                    if (rx_fall) begin
                        abd_q <= AB_START;
                    end
                end
                AB_START: begin
                    if (rx_rise) begin
                        abd_q <= AB_COUNT;
                        abd_cnt_q <= ABD_START;
                        presc_q <= 3'h0;
                        edges_q <= 3'h1;
                    end
                end
                AB_COUNT: begin
                    presc_q <= presc_q + 3'h1;
                    if (presc_tick) begin
                        abd_cnt_q <= abd_cnt_q + 16'h0001;
                    end
                    if (rx_rise) begin
                        edges_q <= edges_q + 3'h1;
                    end
                    if (abd_done) begin
                        abd_q <= AB_IDLE;
                    end
                end
                default: begin
                    abd_q <= AB_IDLE;
                end
            endcase
        end
    end

    // ====================================================
    // Divisor pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= DIV_RST;
        end else if (abd_done) begin
            div_q <= abd_cnt_q;
        end else if (sel(wr_i, addr_i, OFS_DIVLO)) begin
            div_q[7:0] <= wdata_i;
        end else if (sel(wr_i, addr_i, OFS_DIVHI)) begin
            div_q[15:8] <= wdata_i;
        end
    end

    // ====================================================
    // Asynchronous receiver
    assign rx_done = rx_q == RX_STOP && rx_half && rx_go;

    always_ff @(posedge clk_i) begin
        if (rst_i || !rx_go) begin
            rx_q <= RX_IDLE;
            rx_bits_q <= 3'h0;
        end else begin
            unique case (rx_q)
                RX_IDLE: begin
                    if (rx_fall) begin
                        rx_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_half) begin
                        rx_q <= rx_s ? RX_IDLE : RX_DATA;
                        rx_bits_q <= 3'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_half) begin
                        rx_sh_q <= {rx_s, rx_sh_q[7:1]};
                        rx_bits_q <= rx_bits_q + 3'h1;
                        if (rx_bits_q == 3'h7) begin
                            rx_q <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_half) begin
                        rx_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxbuf_q <= 8'h00;
            framing_error_flag_q <= 1'b0;
        // break shows zero and framing error
        end else if (rx_done) begin
            rxbuf_q <= rx_sh_q;
            framing_error_flag_q <= !rx_s;
        end
    end

    // ====================================================
    // Receive-pending flag, set wins over read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= rx_done || abd_done || abd_ovf_evt || wake_evt || (pend_q && !rd_rx);
        end
    end

    // ====================================================
    // Transmit holding register
    assign load = tx_q == TX_IDLE && hold_full_q && ctrl_q.transmit_enable && (async_on || sync_tx);
    assign wr_tx_ok = sel(wr_i, addr_i, OFS_TXDATA) && ctrl_q.transmit_enable && (!hold_full_q || load);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_full_q <= 1'b0;
            hold_brk_q <= 1'b0;
            hold_q <= 8'h00;
        end else begin
            hold_full_q <= wr_tx_ok || (hold_full_q && !load);
            if (wr_tx_ok) begin
                hold_q <= wdata_i;
                // write starts a break, not while one pending
                hold_brk_q <= ctrl_q.send_break_request && !ctrl_q.sync_mode
                    && !(tx_brk_q && tx_q != TX_IDLE) && !(hold_full_q && hold_brk_q);
            end
        end
    end

    // ====================================================
    // Transmit shifter
    assign nbits = tx_brk_q ? BRK_BITS : DATA_BITS;

    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_q.port_enable) begin
            tx_q <= TX_IDLE;
            tx_cnt_q <= 4'h0;
            tx_brk_q <= 1'b0;
            tsr_q <= 8'h00;
        end else begin
            unique case (tx_q)
                TX_IDLE: begin
                    if (load) begin
                        tsr_q <= hold_brk_q ? 8'h00 : hold_q;
                        tx_brk_q <= hold_brk_q;
                        tx_cnt_q <= 4'h0;
                        tx_q <= sync_tx ? TX_SLEAD : TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        tx_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick) begin
                        tsr_q <= {1'b0, tsr_q[7:1]};
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        if (tx_cnt_q == nbits - 4'h1) begin
                            tx_q <= TX_STOP;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        tx_q <= TX_IDLE;
                    end
                end
                TX_SLEAD: begin
                    if (tx_tick) begin
                        tx_q <= TX_STRAIL;
                    end
                end
                TX_STRAIL: begin
                    if (tx_tick) begin
                        tsr_q <= {1'b0, tsr_q[7:1]};
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        tx_q <= (tx_cnt_q == DATA_BITS - 4'h1) ? TX_IDLE : TX_SLEAD;
                    end
                end
                default: begin
                    tx_q <= TX_IDLE;
                end
            endcase
        end
    end

    // ====================================================
    // Pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_pin_o <= 1'b1;
            clock_pin_oe_o <= 1'b0;
            data_pin_o <= 1'b1;
            data_pin_oe_o <= 1'b0;
        end else begin
            clock_pin_oe_o <= ctrl_q.port_enable && (ctrl_q.sync_mode ? ctrl_q.clock_source_master
                : ctrl_q.transmit_enable);
            if (ctrl_q.sync_mode) begin
                clock_pin_o <= ctrl_q.clock_idle_polarity ^ (tx_q == TX_STRAIL);
            end else begin
                clock_pin_o <= !(tx_q == TX_START || (tx_q == TX_DATA && !tsr_q[0]));
            end
            // both drivers on, data on leading edge
            data_pin_oe_o <= sync_tx && ctrl_q.transmit_enable;
            if (tx_q == TX_SLEAD && tx_tick) begin
                data_pin_o <= tsr_q[0];
            end
        end
    end

    // ====================================================
    // Register reads
    always_comb begin
        baud_rd = 8'h00;
        baud_rd[BAUD_ABD_EN] = abd_en_q;
        baud_rd[BAUD_WAKE_EN] = wake_en_q;
        baud_rd[BAUD_IDLE] = recv_idle;
        baud_rd[BAUD_OVF] = ovf_q;
        stat_rd = 8'h00;
        stat_rd[STAT_PEND] = pend_q;
        stat_rd[STAT_FRAMING_ERROR_FLAG] = framing_error_flag_q;
        stat_rd[STAT_TXE] = !hold_full_q;
        stat_rd[STAT_TRMT] = tx_q == TX_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !rd_i) begin
            rdata_o <= 8'h00;
        end else begin
            unique case (addr_i)
                OFS_CTRL: rdata_o <= ctrl_q;
                OFS_BAUD: rdata_o <= baud_rd;
                OFS_STAT: rdata_o <= stat_rd;
                OFS_RXDATA: rdata_o <= rxbuf_q;
                OFS_DIVLO: rdata_o <= div_q[7:0];
                OFS_DIVHI: rdata_o <= div_q[15:8];
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    // ====================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_abd_done;
        abd_done |=> !abd_en_q && pend_q && div_q == $past(abd_cnt_q);
    endproperty
    a_abd_done: assert property (p_abd_done) else $error("autobaud end not applied");

    property p_abd_ovf;
        abd_ovf_evt |=> ovf_q && pend_q && abd_cnt_q == 16'h0000;
    endproperty
    a_abd_ovf: assert property (p_abd_ovf) else $error("overflow not flagged");

    property p_idle_abd;
        abd_go && sel(rd_i, addr_i, OFS_BAUD) |=> !rdata_o[BAUD_IDLE];
    endproperty
    a_idle_abd: assert property (p_idle_abd) else $error("idle high during autobaud");

    property p_idle_rise;
        abd_done |=> recv_idle;
    endproperty
    a_idle_rise: assert property (p_idle_rise) else $error("idle not set at fifth edge");

    property p_wake_set;
        wake_evt |=> pend_q && wake_seen_q;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake event lost");

    property p_wake_clr;
        wake_end && !wr_baud |=> !wake_en_q;
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake enable not cleared");

    sequence s_brk_last;
        tx_q == TX_DATA && tx_brk_q && tx_tick && tx_cnt_q == 4'hB;
    endsequence
    property p_brk_len;
        s_brk_last |=> tx_q == TX_STOP;
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break length wrong");

    property p_brk_end;
        brk_done && !sel(wr_i, addr_i, OFS_CTRL) |=> !ctrl_q.send_break_request && tx_q == TX_IDLE;
    endproperty
    a_brk_end: assert property (p_brk_end) else $error("break request stuck");

    property p_sync_nostart;
        sync_tx |-> tx_q != TX_START && tx_q != TX_STOP;
    endproperty
    a_sync_nostart: assert property (p_sync_nostart) else $error("framing bits in sync mode");

    property p_clk_idle;
        ctrl_q.sync_mode && tx_q != TX_STRAIL ##1 ctrl_q.sync_mode |-> clock_pin_o == $past(ctrl_q.clock_idle_polarity);
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock idle level wrong");
endmodule

// ===== slb_peer.sv
`timescale 1ns/1ps
// ====
// Serial peer on data and clock pins
module slb_peer (
    input wire logic clk_i,
    input wire logic ck_i,
    input wire logic ck_oe_i,
    input wire logic dt_i,
    input wire logic pol_i,
    output logic line_o
);
    logic prev_q = 1'b0;
    logic [15:0] sh_q = 16'h0000;
    int nbits = 0;
    int nlow = 0;
    initial line_o = 1'b1;
    task automatic set_line(input logic b);
        line_o <= b;
    endtask
    task automatic clr();
        nbits = 0;
        nlow = 0;
        sh_q = 16'h0000;
    endtask
    task automatic send(input logic [15:0] bits, input int n, input int bit_cyc);
        for (int i = 0; i < n; i++) begin
            line_o <= bits[i];
            repeat (bit_cyc) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // Low time count; sample on return to idle
    always @(posedge clk_i) begin
        prev_q <= ck_i;
        if (ck_oe_i && !ck_i) begin
            nlow++;
        end
        if (ck_oe_i && prev_q != ck_i && ck_i == pol_i) begin
            sh_q <= {dt_i, sh_q[15:1]};
            nbits++;
        end
    end
endmodule

// ===== slb_lin_serial_tb.sv
`timescale 1ns/1ps
module slb_lin_serial_tb;
    import slb_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic ck_o, ck_oe, dt_o, dt_oe, line;
    logic pol = 1'b0;
    logic [7:0] v;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    initial forever #4 clk_i = ~clk_i;
    slb_lin_serial dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clock_pin_i(ck_oe ? ck_o : 1'b1),
        .clock_pin_o(ck_o), .clock_pin_oe_o(ck_oe), .data_pin_i(dt_oe ? dt_o : line),
        .data_pin_o(dt_o), .data_pin_oe_o(dt_oe));
    slb_peer peer (.clk_i(clk_i), .ck_i(ck_o), .ck_oe_i(ck_oe), .dt_i(dt_o), .pol_i(pol),
        .line_o(line));
    // ====
    // Bus access and compares
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        chk(nm, {8'h00, e}, {8'h00, v & m});
    endtask
    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            close_out();
        end
    end
    // ====
    // Test sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rchk("ctrl", OFS_CTRL, 8'hFF, CTRL_RST);
        rchk("divlo", OFS_DIVLO, 8'hFF, DIV_RST[7:0]);
        rchk("divhi", OFS_DIVHI, 8'hFF, DIV_RST[15:8]);
        rchk("stat", OFS_STAT, 8'h0F, 8'h0C);
        wr(4'hF, 8'hFF);
        rchk("unmapped", 4'hF, 8'hFF, 8'h00);
        wr(OFS_DIVLO, 8'h03);
        wr(OFS_CTRL, 8'h41);
        peer.send(16'h0000, 12, 4);
        repeat (20) @(posedge clk_i);
        rchk("brk_stat", OFS_STAT, 8'h03, 8'h03);
        rchk("brk_data", OFS_RXDATA, 8'hFF, 8'h00);
        peer.send({6'h3F, 1'b1, 8'hC3, 1'b0}, 10, 4);
        repeat (20) @(posedge clk_i);
        rchk("rx_stat", OFS_STAT, 8'h03, 8'h01);
        rchk("rx_data", OFS_RXDATA, 8'hFF, 8'hC3);
        rchk("rx_idle", OFS_BAUD, 8'h40, 8'h40);
        wr(OFS_BAUD, 8'h02);
        peer.set_line(1'b0);
        repeat (60) @(posedge clk_i);
        rchk("wake_pend", OFS_STAT, 8'h01, 8'h01);
        rchk("wake_held", OFS_BAUD, 8'h02, 8'h02);
        peer.set_line(1'b1);
        repeat (10) @(posedge clk_i);
        rchk("wake_end", OFS_BAUD, 8'h02, 8'h00);
        rd(OFS_RXDATA);
        rchk("wake_clr", OFS_STAT, 8'h03, 8'h00);
        wr(OFS_BAUD, 8'h01);
        fork
            peer.send({6'h3F, 1'b1, 8'h55, 1'b0}, 10, 16);
            begin
                repeat (60) @(posedge clk_i);
                rchk("abd_idle", OFS_BAUD, 8'h41, 8'h01);
            end
        join
        repeat (10) @(posedge clk_i);
        rchk("abd_done", OFS_BAUD, 8'hC1, 8'h40);
        rchk("abd_pend", OFS_STAT, 8'h01, 8'h01);
        rd(OFS_DIVLO);
        chk("abd_count", 16'h0001, {15'h0000, v >= 8'h0F && v <= 8'h11});
        rchk("abd_hi", OFS_DIVHI, 8'hFF, 8'h00);
        rd(OFS_RXDATA);
        wr(OFS_BAUD, 8'h00);
        rchk("ovf_clr", OFS_BAUD, 8'hC3, 8'h40);
        wr(OFS_DIVLO, 8'h03);
        wr(OFS_CTRL, 8'h07);
        peer.clr();
        wr(OFS_TXDATA, 8'hA5);
        wr(OFS_TXDATA, 8'h55);
        repeat (250) @(posedge clk_i);
        chk("brk_low", 16'h0048, peer.nlow[15:0]);
        rchk("brk_clr", OFS_CTRL, 8'hFF, 8'h03);
        for (int p = 0; p < 2; p++) begin
            pol <= p[0];
            wr(OFS_CTRL, {p[0], 7'h1B});
            repeat (4) @(posedge clk_i);
            peer.clr();
            wr(OFS_TXDATA, 8'hA6);
            wr(OFS_TXDATA, 8'h5B);
            repeat (200) @(posedge clk_i);
            chk("sync_data", 16'h5BA6, peer.sh_q);
            chk("sync_bits", 16'h0010, peer.nbits[15:0]);
            chk("ck_idle", {15'h0000, p[0]}, {15'h0000, ck_o});
            chk("pin_oe", 16'h0003, {14'h0000, ck_oe, dt_oe});
        end
        close_out();
    end
endmodule
